// ---- rtl/mdc_params.svh ----
`ifndef MDC_PARAMS_SVH
`define MDC_PARAMS_SVH

// register addresses
`define MDC_ADDR_RUN        16'he228
`define MDC_ADDR_FLAGS0     16'he502
`define MDC_ADDR_INTEN0     16'he50a
`define MDC_ADDR_SETUP      16'he618
`define MDC_ADDR_PROT       16'he7e3
`define MDC_ADDR_KEY        16'he7fe
`define MDC_ADDR_PHCAL_A    16'he7a0
`define MDC_ADDR_PHCAL_B    16'he7a1
`define MDC_ADDR_PHCAL_C    16'he7a2
`define MDC_ADDR_RAM_FIRST  16'h4380
`define MDC_ADDR_RAM_LAST   16'h43bf

// field positions and values
`define MDC_BIT_DONE        17
`define MDC_SETUP_PINSEL_LO 0
`define MDC_PINSEL_DONE     2'h0
`define MDC_RUN_START       16'h0001
`define MDC_RUN_STOP        16'h0000
`define MDC_KEY_VALUE       8'had
`define MDC_PROT_ENABLE     8'h80
`define MDC_PROT_DISABLE    8'h00

// reset values
`define MDC_RST_RUN         16'h0000
`define MDC_RST_SETUP       16'h0010
`define MDC_RST_INTEN       32'h0000_0000
`define MDC_RST_PHCAL       10'h000

// phase calibration
`define MDC_PHCAL_LAG_BIT   9
`define MDC_PHCAL_BASE      10'h180
`define MDC_PHCAL_MAX_STEP  383

// timing
`define MDC_SYS_KHZ         200000
`define MDC_PROC_KHZ        1024
`define MDC_PASS_KHZ        8
`define MDC_CLK_PERIOD_PS   5000
`define MDC_PIN_DELAY_NS    70
`define MDC_PIN_LOW_US      10
`define MDC_PASS_TICKS      (`MDC_PROC_KHZ / `MDC_PASS_KHZ)
`define MDC_PIN_DELAY_CYC   ((`MDC_PIN_DELAY_NS * 1000 + `MDC_CLK_PERIOD_PS - 1) / `MDC_CLK_PERIOD_PS)
`define MDC_PIN_LOW_CYC     ((`MDC_PIN_LOW_US * 1000000) / `MDC_CLK_PERIOD_PS)

`endif

// ---- rtl/mdc_pkg.sv ----
package mdc_pkg;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [31:0] wdata;
   } mdc_req_s;

   typedef struct packed {
      logic        valid;
      logic [31:0] rdata;
   } mdc_rsp_s;

   typedef struct packed {
      logic [23:0] v;
      logic [23:0] i;
   } mdc_phase_s;

   typedef struct packed {
      logic        valid;
      logic [5:0]  idx;
      logic [27:0] data;
   } mdc_ram_wr_s;

   typedef enum logic [1:0] {
      MDC_PIN_IDLE,
      MDC_PIN_WAIT,
      MDC_PIN_LOW
   } mdc_pin_e;

endpackage

// ---- rtl/mdc_mem.sv ----
`timescale 1ns/10ps
`default_nettype none
module mdc_mem #(
   parameter int W  = 28,
   parameter int AW = 6
) (
   input  wire logic          clk_sys,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic [AW-1:0] raddr_a,
   input  wire logic [AW-1:0] raddr_b,
   output logic      [W-1:0]  rdata_a,
   output logic      [W-1:0]  rdata_b
);

   logic [W-1:0] mem [2**AW];

   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
   end

endmodule
`default_nettype wire

// ---- rtl/mdc_phase_delay.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "mdc_params.svh"
module mdc_phase_delay import mdc_pkg::*; (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             tick,
   input  wire logic [2:0][9:0]  cal,
   input  wire mdc_phase_s [2:0] phase_in,
   output mdc_phase_s [2:0]      phase_out
);

   // read distance = base + signed steps; lag bit set means delay
   function automatic logic [9:0] delay_of(input logic [9:0] c);
      logic [9:0] mag;
      mag = {1'b0, c[8:0]};
      if (c[`MDC_PHCAL_LAG_BIT]) begin
         delay_of = `MDC_PHCAL_BASE + mag;
      end else begin
         delay_of = `MDC_PHCAL_BASE - mag;
      end
   endfunction

   logic [9:0] wp;
   logic       tick_q;
   logic       filled;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wp     <= 10'h000;
         tick_q <= 1'b0;
         filled <= 1'b0;
      end else begin
         tick_q <= tick;
         if (tick) begin
            wp <= wp + 10'h001;
            if (wp == 10'h3ff) begin
               filled <= 1'b1;
            end
         end
      end
   end

   for (genvar g = 0; g < 3; g++) begin : g_ph
      wire [9:0] rd_v = wp - delay_of(cal[g]);
      wire [9:0] rd_i = wp - `MDC_PHCAL_BASE;
      logic [47:0] q_v;
      logic [47:0] q_i;

      mdc_mem #(.W(48), .AW(10)) u_buf (
         .clk_sys (clk_sys),
         .we      (tick),
         .waddr   (wp),
         .wdata   (phase_in[g]),
         .raddr_a (rd_v),
         .raddr_b (rd_i),
         .rdata_a (q_v),
         .rdata_b (q_i)
      );

      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            phase_out[g] <= '0;
         end else if (tick_q && filled) begin
            phase_out[g] <= {q_v[47:24], q_i[23:0]};
         end
      end
   end

endmodule
`default_nettype wire

// ---- rtl/mdc_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "mdc_params.svh"
module mdc_top import mdc_pkg::*; (
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   input  wire logic             sw_reset,
   input  wire mdc_req_s         reg_req,
   input  wire mdc_phase_s [2:0] phase_in,
   output mdc_rsp_s              reg_rsp,
   output logic                  irq_line_0_n,
   output logic                  shared_output_pin,
   output logic                  dsp_running,
   output logic                  compute_done,
   output logic                  ram_clear_busy,
   output mdc_phase_s [2:0]      phase_out
);

   function automatic logic is_ram(input logic [15:0] a);
      is_ram = (a >= `MDC_ADDR_RAM_FIRST) && (a <= `MDC_ADDR_RAM_LAST);
   endfunction

   // hardware and software reset act alike
   wire rst_n = rstn & ~sw_reset;

   // request decode
   wire        wr       = reg_req.wr;
   wire [15:0] addr     = reg_req.addr;
   wire [31:0] wdata    = reg_req.wdata;
   wire        hit_run  = addr == `MDC_ADDR_RUN;
   wire        hit_flg  = addr == `MDC_ADDR_FLAGS0;
   wire        hit_ien  = addr == `MDC_ADDR_INTEN0;
   wire        hit_set  = addr == `MDC_ADDR_SETUP;
   wire        hit_prot = addr == `MDC_ADDR_PROT;
   wire        hit_key  = addr == `MDC_ADDR_KEY;
   wire        hit_pha  = addr == `MDC_ADDR_PHCAL_A;
   wire        hit_phb  = addr == `MDC_ADDR_PHCAL_B;
   wire        hit_phc  = addr == `MDC_ADDR_PHCAL_C;
   wire        hit_ram  = is_ram(addr);

   // registers
   logic [15:0]      run_ctl;
   logic [31:0]      int_en;
   logic [15:0]      setup;
   logic [7:0]       prot_ctl;
   logic [7:0]       key_reg;
   logic             key_armed;
   logic [2:0][9:0]  phcal;
   logic             done_flag;

   // processing clock and pass timing
   logic [17:0]      proc_acc;
   logic             proc_tick;
   logic [6:0]       pass_cnt;

   // data RAM pipeline and clear walk
   mdc_ram_wr_s      stage1;
   mdc_ram_wr_s      stage2;
   logic [6:0]       clr_idx;
   logic [27:0]      ram_q;

   // pin pulse
   mdc_pin_e         pin_st;
   logic [10:0]      pin_cnt;

   // read pipeline
   logic             rd_q;
   logic [15:0]      rd_addr_q;

   wire        running    = run_ctl == `MDC_RUN_START;
   wire        protect_on = prot_ctl == `MDC_PROT_ENABLE;
   wire        clearing   = ~clr_idx[6];
   wire [1:0]  pin_sel    = setup[`MDC_SETUP_PINSEL_LO +: 2];

   // processing clock: exact 1.024 MHz average by fractional accumulation
   wire [17:0] acc_sum    = proc_acc + 18'(`MDC_PROC_KHZ);
   wire        acc_wrap   = acc_sum >= 18'(`MDC_SYS_KHZ);
   wire [17:0] next_acc   = acc_wrap ? acc_sum - 18'(`MDC_SYS_KHZ) : acc_sum;
   wire        done_evt   = running && proc_tick && (pass_cnt == 7'(`MDC_PASS_TICKS - 1));

   // protection sequence
   wire        key_ok     = wdata[7:0] == `MDC_KEY_VALUE;
   wire        prot_val   = (wdata[7:0] == `MDC_PROT_ENABLE) || (wdata[7:0] == `MDC_PROT_DISABLE);
   wire        prot_upd   = wr && hit_prot && key_armed && prot_val;

   // data RAM writes
   wire        ram_wr_ok  = wr && hit_ram && !protect_on && !clearing;
   wire        commit     = ram_wr_ok && stage2.valid;
   wire        mem_we     = clearing | commit;
   wire [5:0]  mem_waddr  = clearing ? clr_idx[5:0] : stage2.idx;
   wire [27:0] mem_wdata  = clearing ? 28'h000_0000 : stage2.data;

   // flag write-one-to-clear, set wins
   wire        done_clr   = wr && hit_flg && wdata[`MDC_BIT_DONE];
   wire        next_done  = done_evt | (done_flag & ~done_clr);

   // read data select
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (is_ram(rd_addr_q)) begin
         rd_mux = {4'h0, ram_q};
      end else begin
         case (rd_addr_q)
            `MDC_ADDR_RUN:     rd_mux = {16'h0000, run_ctl};
            `MDC_ADDR_FLAGS0:  rd_mux = 32'(done_flag) << `MDC_BIT_DONE;
            `MDC_ADDR_INTEN0:  rd_mux = int_en;
            `MDC_ADDR_SETUP:   rd_mux = {16'h0000, setup};
            `MDC_ADDR_PROT:    rd_mux = {24'h00_0000, prot_ctl};
            `MDC_ADDR_KEY:     rd_mux = {24'h00_0000, key_reg};
            `MDC_ADDR_PHCAL_A: rd_mux = {22'h0, phcal[0]};
            `MDC_ADDR_PHCAL_B: rd_mux = {22'h0, phcal[1]};
            `MDC_ADDR_PHCAL_C: rd_mux = {22'h0, phcal[2]};
            default:           rd_mux = 32'h0000_0000;
         endcase
      end
   end

   // control registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         run_ctl <= `MDC_RST_RUN;
         int_en  <= `MDC_RST_INTEN;
         setup   <= `MDC_RST_SETUP;
         key_reg <= 8'h00;
      end else if (wr) begin
         if (hit_run) begin
            run_ctl <= wdata[15:0];
         end
         if (hit_ien) begin
            int_en <= wdata;
         end
         if (hit_set) begin
            setup <= wdata[15:0];
         end
         if (hit_key) begin
            key_reg <= wdata[7:0];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         phcal <= {3{`MDC_RST_PHCAL}};
      end else if (wr) begin
         if (hit_pha) begin
            phcal[0] <= wdata[9:0];
         end
         if (hit_phb) begin
            phcal[1] <= wdata[9:0];
         end
         if (hit_phc) begin
            phcal[2] <= wdata[9:0];
         end
      end
   end

   // key arms only the very next write
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         key_armed <= 1'b0;
         prot_ctl  <= `MDC_PROT_DISABLE;
      end else begin
         if (wr) begin
            key_armed <= hit_key && key_ok;
         end
         if (prot_upd) begin
            prot_ctl <= wdata[7:0];
         end
      end
   end

   // processing tick and pass counter
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         proc_acc  <= 18'h0;
         proc_tick <= 1'b0;
      end else begin
         proc_acc  <= next_acc;
         proc_tick <= acc_wrap;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n || !running) begin
         pass_cnt <= 7'h00;
      end else if (proc_tick) begin
         pass_cnt <= pass_cnt + 7'h01;
      end
   end

   // flag, irq and status outputs
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         done_flag    <= 1'b0;
         irq_line_0_n <= 1'b1;
         compute_done <= 1'b0;
         dsp_running  <= 1'b0;
      end else begin
         done_flag    <= next_done;
         irq_line_0_n <= ~(next_done & int_en[`MDC_BIT_DONE]);
         compute_done <= done_evt;
         dsp_running  <= running;
      end
   end

   // two-stage write pipeline
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stage1 <= '0;
         stage2 <= '0;
      end else if (ram_wr_ok) begin
         stage1 <= '{valid: 1'b1, idx: addr[5:0], data: wdata[27:0]};
         stage2 <= stage1;
      end
   end

   // zero the RAM after every reset
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         clr_idx        <= 7'h00;
         ram_clear_busy <= 1'b1;
      end else begin
         if (clearing) begin
            clr_idx <= clr_idx + 7'h01;
         end
         ram_clear_busy <= clearing && (clr_idx != 7'h3f);
      end
   end

   mdc_mem #(.W(28), .AW(6)) u_ram (
      .clk_sys (clk_sys),
      .we      (mem_we),
      .waddr   (mem_waddr),
      .wdata   (mem_wdata),
      .raddr_a (addr[5:0]),
      .raddr_b (6'h00),
      .rdata_a (ram_q),
      .rdata_b ()
   );

   // register reads answer two cycles later
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rd_q      <= 1'b0;
         rd_addr_q <= 16'h0000;
         reg_rsp   <= '0;
      end else begin
         rd_q          <= reg_req.rd;
         rd_addr_q     <= addr;
         reg_rsp.valid <= rd_q;
         reg_rsp.rdata <= rd_q ? rd_mux : 32'h0000_0000;
      end
   end

   // compute-done pulse on the shared pin
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_st            <= MDC_PIN_IDLE;
         pin_cnt           <= 11'h000;
         shared_output_pin <= 1'b1;
      end else begin
         case (pin_st)
            MDC_PIN_IDLE: begin
               if (done_evt && pin_sel == `MDC_PINSEL_DONE) begin
                  pin_st  <= MDC_PIN_WAIT;
                  pin_cnt <= 11'(`MDC_PIN_DELAY_CYC - 2);
               end
            end
            MDC_PIN_WAIT: begin
               if (pin_cnt == 11'h000) begin
                  pin_st            <= MDC_PIN_LOW;
                  pin_cnt           <= 11'(`MDC_PIN_LOW_CYC - 1);
                  shared_output_pin <= 1'b0;
               end else begin
                  pin_cnt <= pin_cnt - 11'h001;
               end
            end
            MDC_PIN_LOW: begin
               if (pin_cnt == 11'h000) begin
                  pin_st            <= MDC_PIN_IDLE;
                  shared_output_pin <= 1'b1;
               end else begin
                  pin_cnt <= pin_cnt - 11'h001;
               end
            end
            default: begin
               pin_st            <= MDC_PIN_IDLE;
               shared_output_pin <= 1'b1;
            end
         endcase
      end
   end

   mdc_phase_delay u_phase (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .tick      (proc_tick),
      .cal       (phcal),
      .phase_in  (phase_in),
      .phase_out (phase_out)
   );

endmodule
`default_nettype wire

// ---- test/mdc_top_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "mdc_params.svh"
module mdc_top_monitor import mdc_pkg::*; (
   input wire logic     clk_sys,
   input wire logic     rstn,
   input wire logic     sw_reset,
   input wire mdc_req_s reg_req,
   input wire mdc_rsp_s reg_rsp,
   input wire logic     irq_line_0_n,
   input wire logic     shared_output_pin,
   input wire logic     dsp_running,
   input wire logic     compute_done
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn || sw_reset);
   logic [14:0] gap;
   logic [11:0] low_cnt;
   logic        armed;
   wire         rst_any = !rstn || sw_reset;
   wire         run_wr = reg_req.wr && reg_req.addr == `MDC_ADDR_RUN;
   wire         clr_wr = reg_req.wr && reg_req.addr == `MDC_ADDR_FLAGS0 && reg_req.wdata[`MDC_BIT_DONE];
   always_ff @(posedge clk_sys) begin
      if (rst_any || !dsp_running || compute_done) gap <= '0;
      else gap <= gap + 15'h1;
      if (rst_any || !dsp_running) armed <= 1'b0;
      else if (compute_done) armed <= 1'b1;
      if (rst_any || shared_output_pin) low_cnt <= '0;
      else low_cnt <= low_cnt + 12'h1;
   end
   property p_reset_idle;
      $rose(rstn) |-> !dsp_running && !compute_done && irq_line_0_n && shared_output_pin;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("outputs not idle after reset");
   property p_run_start;
      run_wr && reg_req.wdata[15:0] == `MDC_RUN_START |-> ##[1:3] dsp_running;
   endproperty
   a_run_start: assert property (p_run_start)
      else $error("start write did not run");
   property p_run_stop;
      run_wr && reg_req.wdata[15:0] == `MDC_RUN_STOP |-> ##[1:3] !dsp_running;
   endproperty
   a_run_stop: assert property (p_run_stop)
      else $error("stop write did not stop");
   property p_done_run;
      compute_done |-> dsp_running;
   endproperty
   a_done_run: assert property (p_done_run)
      else $error("pass ended while idle");
   property p_pass;
      compute_done && armed |-> gap >= 24995 && gap <= 25005;
   endproperty
   a_pass: assert property (p_pass)
      else $error("pass period wrong");
   property p_irq_set;
      $fell(irq_line_0_n) |-> compute_done;
   endproperty
   a_irq_set: assert property (p_irq_set)
      else $error("irq low without pass end");
   property p_irq_clr;
      clr_wr |-> ##2 (irq_line_0_n || compute_done || $past(compute_done));
   endproperty
   a_irq_clr: assert property (p_irq_clr)
      else $error("irq not released by clear");
   property p_pin_early;
      $rose(compute_done) |-> shared_output_pin [*8];
   endproperty
   a_pin_early: assert property (p_pin_early)
      else $error("pin fell too early");
   property p_pin_width;
      $rose(shared_output_pin) && !$past(rst_any) |-> low_cnt == 12'd2000;
   endproperty
   a_pin_width: assert property (p_pin_width)
      else $error("pin low width wrong");
   property p_rd_ans;
      reg_req.rd |-> ##2 reg_rsp.valid;
   endproperty
   a_rd_ans: assert property (p_rd_ans)
      else $error("read not answered");
   property p_no_rsp;
      !reg_req.rd |-> ##2 !reg_rsp.valid;
   endproperty
   a_no_rsp: assert property (p_no_rsp)
      else $error("answer without read");
endmodule
`default_nettype wire

// ---- test/mdc_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "mdc_params.svh"
module mdc_host_model import mdc_pkg::*; (
   input  wire logic     clk_sys,
   input  wire mdc_rsp_s reg_rsp,
   output var mdc_req_s  reg_req
);
   initial reg_req = '0;
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys);
      reg_req <= '0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      int n;
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk_sys);
      reg_req <= '0;
      d = 'x;
      for (n = 0; n < 4 && reg_rsp.valid !== 1'b1; n++) @(posedge clk_sys);
      if (reg_rsp.valid === 1'b1) d = reg_rsp.rdata;
   endtask
   // lead as magnitude, lag plus 512, steps kept within 383
   function automatic logic [31:0] enc(input int step);
      if (step > 383 || step < -383) step = 0;
      return (step < 0) ? 32'(-step) : 32'(step + 512);
   endfunction
   // key write directly before the protection write
   task automatic protect(input logic on);
      wr(`MDC_ADDR_KEY, {24'h0, `MDC_KEY_VALUE});
      wr(`MDC_ADDR_PROT, {24'h0, on ? `MDC_PROT_ENABLE : `MDC_PROT_DISABLE});
   endtask
   // last ram write repeated twice to flush the pipeline
   task automatic flush(input logic [15:0] a, input logic [31:0] d);
      wr(a, d);
      wr(a, d);
   endtask
endmodule
`default_nettype wire

// ---- test/test_metering_dsp_control.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "mdc_params.svh"
module test_metering_dsp_control import mdc_pkg::*;;
   localparam logic [15:0] ram_lo = `MDC_ADDR_RAM_FIRST;
   localparam logic [15:0] ram_hi = `MDC_ADDR_RAM_LAST;
   logic             clk_sys;
   logic             rstn;
   logic             sw_reset;
   mdc_req_s         reg_req;
   mdc_rsp_s         reg_rsp;
   mdc_phase_s [2:0] phase_in;
   mdc_phase_s [2:0] phase_out;
   logic             irq_line_0_n;
   logic             shared_output_pin;
   logic             dsp_running;
   logic             compute_done;
   logic             ram_clear_busy;
   int               err_count;
   int               cmp_count;
   int               n;
   mdc_top dut (.clk_sys(clk_sys), .rstn(rstn), .sw_reset(sw_reset), .reg_req(reg_req),
      .phase_in(phase_in), .reg_rsp(reg_rsp), .irq_line_0_n(irq_line_0_n),
      .shared_output_pin(shared_output_pin), .dsp_running(dsp_running),
      .compute_done(compute_done), .ram_clear_busy(ram_clear_busy), .phase_out(phase_out));
   mdc_host_model h (.clk_sys(clk_sys), .reg_rsp(reg_rsp), .reg_req(reg_req));
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic expect_rd(input logic [15:0] a, input logic [31:0] e);
      logic [31:0] d;
      h.rd(a, d);
      check($sformatf("read %h", a), d, e);
   endtask
   task automatic give_verdict();
      $display("compares %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      #450000;
      err_count++;
      give_verdict();
   end
   initial begin
      rstn = 1'b0;
      sw_reset = 1'b0;
      phase_in = {48'h3333_3333_3333, 48'h2222_2222_2222, 48'h1111_1111_1111};
      err_count = 0;
      cmp_count = 0;
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      expect_rd(`MDC_ADDR_RUN, 32'h0);
      expect_rd(16'h1234, 32'h0);
      h.wr(`MDC_ADDR_PHCAL_A, h.enc(-383));
      h.wr(`MDC_ADDR_PHCAL_B, h.enc(383));
      h.wr(`MDC_ADDR_PHCAL_C, 32'hffff_ffff);
      expect_rd(`MDC_ADDR_PHCAL_A, 32'h17f);
      expect_rd(`MDC_ADDR_PHCAL_B, 32'h37f);
      expect_rd(`MDC_ADDR_PHCAL_C, 32'h3ff);
      for (n = 0; n < 100 && ram_clear_busy !== 1'b0; n++) @(posedge clk_sys);
      check("ram clear", {31'h0, ram_clear_busy}, 32'h0);
      expect_rd(ram_hi, 32'h0);
      h.wr(ram_lo, 32'hfabc_def1);
      expect_rd(ram_lo, 32'h0);
      h.flush(ram_hi, 32'h5);
      expect_rd(ram_lo, 32'h0abc_def1);
      h.protect(1'b1);
      expect_rd(`MDC_ADDR_PROT, 32'h80);
      repeat (3) h.wr(ram_lo, 32'h1);
      expect_rd(ram_lo, 32'h0abc_def1);
      h.wr(`MDC_ADDR_PROT, 32'h0);
      expect_rd(`MDC_ADDR_PROT, 32'h80);
      h.protect(1'b0);
      expect_rd(`MDC_ADDR_PROT, 32'h0);
      h.wr(ram_lo, 32'h2);
      h.flush(ram_lo, 32'h2);
      expect_rd(ram_lo, 32'h2);
      h.wr(`MDC_ADDR_SETUP, 32'h0);
      h.wr(`MDC_ADDR_INTEN0, 32'h1 << `MDC_BIT_DONE);
      h.wr(`MDC_ADDR_RUN, {16'h0, `MDC_RUN_START});
      expect_rd(`MDC_ADDR_RUN, 32'h1);
      for (n = 0; n < 30000 && compute_done !== 1'b1; n++) @(posedge clk_sys);
      check("irq low", {31'h0, irq_line_0_n}, 32'h0);
      repeat (20) @(posedge clk_sys);
      check("pin low", {31'h0, shared_output_pin}, 32'h0);
      h.wr(`MDC_ADDR_SETUP, 32'h1);
      for (n = 0; n < 30000 && compute_done !== 1'b1; n++) @(posedge clk_sys);
      check("pin high", {31'h0, shared_output_pin}, 32'h1);
      repeat (20) @(posedge clk_sys);
      check("pin select", {31'h0, shared_output_pin}, 32'h1);
      check("phase out", {31'h0, |phase_out}, 32'h0);
      h.wr(`MDC_ADDR_FLAGS0, 32'h1 << `MDC_BIT_DONE);
      repeat (3) @(posedge clk_sys);
      check("irq high", {31'h0, irq_line_0_n}, 32'h1);
      expect_rd(`MDC_ADDR_FLAGS0, 32'h0);
      h.wr(`MDC_ADDR_RUN, {16'h0, `MDC_RUN_STOP});
      repeat (3) @(posedge clk_sys);
      check("stopped", {31'h0, dsp_running}, 32'h0);
      h.wr(`MDC_ADDR_RUN, {16'h0, `MDC_RUN_START});
      sw_reset <= 1'b1;
      @(posedge clk_sys);
      sw_reset <= 1'b0;
      expect_rd(`MDC_ADDR_RUN, 32'h0);
      for (n = 0; n < 100 && ram_clear_busy !== 1'b0; n++) @(posedge clk_sys);
      expect_rd(ram_lo, 32'h0);
      give_verdict();
   end
endmodule
bind mdc_top mdc_top_monitor mon (.clk_sys(clk_sys), .rstn(rstn), .sw_reset(sw_reset),
   .reg_req(reg_req), .reg_rsp(reg_rsp), .irq_line_0_n(irq_line_0_n),
   .shared_output_pin(shared_output_pin), .dsp_running(dsp_running), .compute_done(compute_done));
`default_nettype wire
